// ==== verilog/sadc_port.sv ====
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// RULE1 - master clock runs at 384x word rate with ratio high, 256x with it low
// RULE2 - filter clock output runs at 128x output word rate in both settings
// RULE3 - ratio low: filter clock is master clock divided by two, fixed phase
// RULE4 - ratio high: filter clock is master clock divided by three, two phases
// RULE5 - powerdown release taken next edge; phase by channel select before edge two
// RULE6 - three modes: master, slave window high, slave window controlled
// RULE7 - master mode drives bit clock, channel select, frame window from master clock
// RULE8 - master frame window rises one bit after channel edge, spans 16 data bits
// RULE9 - slave mode: far side drives channel select and bit clock at word rate
// RULE10 - slave bit clock should be half the filter clock rate
// RULE11 - slave: msb on channel select edge, later bits on active bit clock edge
// RULE12 - slave window high: bits shift right after channel edge, no gating
// RULE13 - slave window controlled: low holds msb and ignores bit clock
// RULE14 - after data bits send three tag bits then one channel indicator
// RULE15 - tag field encodes input level bands, most significant first
// RULE16 - channel indicator is 0 for left and 1 for right
// RULE17 - remaining slots filled with ones for left, zeros for right
// RULE18 - samples are 16-bit two's complement, msb first
// RULE19 - both words in one channel period come from the same sample instant
// RULE20 - bits change on rising bit clock; invert option moves to falling edge
// RULE21 - overrange inputs saturate at full scale, degree reported in tags
// RULE22 - board routes filter clock output back to modulator clock input
// RULE23 - during calibration both channel words are forced to zero; code zeros data and tags only, indicator and fill still sent
module sadc_port #(
   parameter int unsigned CAL_WORDS = sadc_pkg::SADC_CAL_WORDS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire sadc_pkg::sadc_pair_type sample_pair,
   input wire logic sample_valid,
   input wire logic digital_powerdown,
   input wire logic chan_sel_i,
   input wire logic bit_clock_i,
   input wire logic frame_window_i,
   output logic chan_sel_o,
   output logic chan_sel_oe,
   output logic bit_clock_o,
   output logic bit_clock_oe,
   output logic frame_window_o,
   output logic frame_window_oe,
   output logic filter_clock_out,
   output logic serial_out,
   output logic cal_busy
);
   import sadc_pkg::*;

   localparam logic [12:0] CAL_LAST = 13'(CAL_WORDS - 1);

   sadc_ctrl_type ctrl_q;
   sadc_state_type state_q;
   sadc_state_type state_d;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [3:0] s1_q;
   logic [3:0] s2_q;
   logic [3:0] s3_q;
   logic [3:0] filt_q;
   logic lr_f;
   logic bclk_f;
   logic fw_f;
   logic pd_f;
   logic lr_prev_q;
   logic bclk_prev_q;
   logic [1:0] align_cnt_q;
   logic lr_seen_q;
   logic phase_q;
   logic [12:0] cal_cnt_q;
   logic cal_busy_q;
   logic [1:0] fcnt_q;
   logic fclk_q;
   logic bclk_q;
   logic bclk_out_q;
   logic [4:0] slot_q;
   logic lr_q;
   logic fw_q;
   logic [31:0] word_q;
   logic fill_q;
   logic serial_q;
   logic cs_oe_q;
   logic bc_oe_q;
   logic fw_oe_q;
   sadc_pair_type pending_q;
   sadc_pair_type cur_q;

   logic run;
   logic is_master;
   logic lr_edge;
   logic lr_rise;
   logic early_now;
   logic bclk_act;
   logic [1:0] div_limit;
   logic tick;
   logic m_active;
   logic [4:0] nslot;
   logic load_left;
   logic word_left;
   logic [31:0] next_word;
   logic acc;

   assign lr_f = filt_q[0];
   assign bclk_f = filt_q[1];
   assign fw_f = filt_q[2];
   assign pd_f = filt_q[3];
   assign run = (state_q == SADC_CAL) || (state_q == SADC_RUN);
   assign is_master = (ctrl_q.mode == SADC_MODE_MASTER);
   assign lr_edge = lr_f ^ lr_prev_q;
   assign lr_rise = lr_f & ~lr_prev_q;
   assign early_now = lr_seen_q | lr_rise;
   assign bclk_act = ctrl_q.invert ? (bclk_prev_q & ~bclk_f) : (~bclk_prev_q & bclk_f); // RULE20
   assign div_limit = ctrl_q.ratio_high ? SADC_DIV3_LIMIT : SADC_DIV2_LIMIT; // RULE1
   assign tick = run && (fcnt_q == 2'h0);
   assign m_active = tick & ~bclk_q;
   assign nslot = 5'(slot_q + 5'h01);
   assign word_left = is_master ? ~lr_q : lr_f;
   assign load_left = run && word_left && (is_master ? (m_active && (nslot == 5'h00)) : lr_edge);
   assign acc = psel & penable & ~pready_q;

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign chan_sel_o = lr_q;
   assign chan_sel_oe = cs_oe_q;
   assign bit_clock_o = bclk_out_q;
   assign bit_clock_oe = bc_oe_q;
   assign frame_window_o = fw_q;
   assign frame_window_oe = fw_oe_q;
   assign filter_clock_out = fclk_q;
   assign serial_out = serial_q;
   assign cal_busy = cal_busy_q;

   function automatic logic [2:0] tag_of(input logic [17:0] mag);
      if (mag >= SADC_LVL_O3)
         tag_of = 3'h7;
      else if (mag >= SADC_LVL_O2)
         tag_of = 3'h6;
      else if (mag >= SADC_LVL_O1)
         tag_of = 3'h5;
      else if (mag >= SADC_LVL_FS)
         tag_of = 3'h4;
      else if (mag >= SADC_LVL_DB1)
         tag_of = 3'h3;
      else if (mag >= SADC_LVL_DB3)
         tag_of = 3'h2;
      else if (mag >= SADC_LVL_DB6)
         tag_of = 3'h1;
      else
         tag_of = 3'h0;
   endfunction

   // one channel word: data, tags, indicator, fill
   function automatic logic [31:0] build_word(input logic signed [17:0] x, input logic left, input logic zero);
      logic [17:0] mag;
      logic [15:0] data;
      logic [2:0] tag;
      mag = x[17] ? 18'(-x) : x;
      if (zero)
      begin
         data = 16'h0000; // RULE23
         tag = 3'h0;
      end
      else
      begin
         tag = tag_of(mag); // RULE15 RULE21
         if (x > SADC_POS_FS)
            data = SADC_SAT_POS; // RULE21
         else if (x < SADC_NEG_FS)
            data = SADC_SAT_NEG; // RULE21
         else
            data = x[15:0]; // RULE18
      end
      build_word = {data, tag, ~left, {SADC_FILL_BITS{left}}}; // RULE14 RULE16 RULE17
   endfunction

   assign next_word = build_word(word_left ? pending_q.left : cur_q.right, word_left, state_q == SADC_CAL);

   // pin synchronisers: a change counts once stages two and three agree
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_q <= 4'h8;
         s2_q <= 4'h8;
         s3_q <= 4'h8;
         filt_q <= 4'h8;
         lr_prev_q <= 1'b0;
         bclk_prev_q <= 1'b0;
      end
      else if (clk_en)
      begin
         s1_q <= {digital_powerdown, frame_window_i, bit_clock_i, chan_sel_i};
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
         lr_prev_q <= lr_f;
         bclk_prev_q <= bclk_f;
      end
   end

   // apb slave, one wait state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         ctrl_q <= SADC_CTRL_RESET;
      end
      else if (clk_en)
      begin
         pready_q <= acc;
         if (acc)
         begin
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            if (paddr == SADC_CTRL_ADDR)
               prdata_q <= {28'h000_0000, ctrl_q};
            else if (paddr == SADC_STATUS_ADDR)
            begin
               prdata_q[SADC_STAT_CAL_BIT] <= cal_busy_q;
               prdata_q[SADC_STAT_PD_BIT] <= (state_q == SADC_PD);
               prdata_q[SADC_STAT_PHASE_BIT] <= phase_q;
               prdata_q[SADC_STAT_RUN_BIT] <= (state_q == SADC_RUN);
            end
            else
               pslverr_q <= 1'b1;
         end
         if (psel && penable && pready_q && pwrite && (paddr == SADC_CTRL_ADDR))
            ctrl_q <= pwdata[SADC_CTRL_WIDTH-1:0]; // RULE6
      end
   end

   // power state sequence
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         SADC_PD:
            state_d = SADC_ALIGN; // RULE5
         SADC_ALIGN:
            if (align_cnt_q == SADC_ALIGN_LAST)
               state_d = SADC_CAL;
         SADC_CAL:
            if (load_left && (cal_cnt_q == CAL_LAST))
               state_d = SADC_RUN;
         default:
            state_d = SADC_RUN;
      endcase
      if (pd_f)
         state_d = SADC_PD;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= SADC_PD;
         cal_busy_q <= 1'b0;
         align_cnt_q <= 2'h0;
         lr_seen_q <= 1'b0;
         phase_q <= 1'b0;
         cal_cnt_q <= 13'h0000;
      end
      else if (clk_en)
      begin
         state_q <= state_d;
         cal_busy_q <= (state_d == SADC_CAL);
         if (state_q == SADC_ALIGN)
         begin
            align_cnt_q <= 2'(align_cnt_q + 2'h1);
            lr_seen_q <= early_now;
            if (align_cnt_q == SADC_ALIGN_LAST)
               phase_q <= early_now; // RULE5
         end
         else
         begin
            align_cnt_q <= 2'h0;
            lr_seen_q <= 1'b0;
         end
         if (state_q != SADC_CAL)
            cal_cnt_q <= 13'h0000;
         else if (load_left)
            cal_cnt_q <= 13'(cal_cnt_q + 13'h0001);
      end
   end

   // filter clock divider, held while powered down
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fcnt_q <= 2'h0;
         fclk_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (!run)
         begin
            if (!ctrl_q.ratio_high)
               fcnt_q <= 2'h0; // RULE3
            else if (early_now)
               fcnt_q <= SADC_DIV3_START_EARLY; // RULE4 RULE5
            else
               fcnt_q <= SADC_DIV3_START_LATE; // RULE4 RULE5
         end
         else if (fcnt_q >= div_limit)
            fcnt_q <= 2'h0; // RULE2
         else
            fcnt_q <= 2'(fcnt_q + 2'h1);
         fclk_q <= run && (fcnt_q >= div_limit); // RULE2 RULE3 RULE4
      end
   end

   // master bit clock at half the filter clock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bclk_q <= 1'b0;
         bclk_out_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (!run)
            bclk_q <= 1'b0;
         else if (tick)
            bclk_q <= ~bclk_q; // RULE7
         bclk_out_q <= (run && tick ? ~bclk_q : (run & bclk_q)) ^ ctrl_q.invert; // RULE20
      end
   end

   // pin drive enables
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cs_oe_q <= 1'b0;
         bc_oe_q <= 1'b0;
         fw_oe_q <= 1'b0;
      end
      else if (clk_en)
      begin
         cs_oe_q <= is_master; // RULE7 RULE9
         bc_oe_q <= is_master; // RULE7 RULE9
         fw_oe_q <= is_master; // RULE7
      end
   end

   // sample pairing
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pending_q <= '0;
         cur_q <= '0;
      end
      else if (clk_en)
      begin
         if (sample_valid)
            pending_q <= sample_pair;
         if (load_left)
            cur_q <= pending_q; // RULE19
      end
   end

   // serial word engine
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         slot_q <= SADC_SLOT_LAST;
         lr_q <= 1'b0;
         fw_q <= 1'b0;
         word_q <= 32'h0000_0000;
         fill_q <= 1'b0;
         serial_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (!run)
         begin
            slot_q <= SADC_SLOT_LAST;
            lr_q <= 1'b0;
            fw_q <= 1'b0;
            word_q <= 32'h0000_0000;
         end
         else if (is_master)
         begin
            if (m_active)
            begin
               slot_q <= nslot;
               fw_q <= (nslot >= SADC_FRAME_FIRST) && (nslot <= SADC_FRAME_LAST); // RULE8
               if (nslot == 5'h00)
               begin
                  lr_q <= ~lr_q; // RULE7
                  word_q <= next_word;
                  fill_q <= word_left;
               end
               else
               begin
                  serial_q <= word_q[31]; // RULE18 RULE20
                  word_q <= {word_q[30:0], fill_q}; // RULE17
               end
            end
         end
         else if (lr_edge)
         begin
            serial_q <= next_word[31]; // RULE11 RULE9
            word_q <= {next_word[30:0], word_left};
            fill_q <= word_left;
         end
         else if (bclk_act && ((ctrl_q.mode == SADC_MODE_SLAVE_HIGH) || fw_f)) // RULE12 RULE13 RULE10
         begin
            serial_q <= word_q[31]; // RULE11
            word_q <= {word_q[30:0], fill_q}; // RULE17
         end
      end
   end
endmodule
`default_nettype wire

// ==== verilog/sadc_pkg.sv ====
`default_nettype none
package sadc_pkg;
   // register byte offsets
   localparam logic [11:0] SADC_CTRL_ADDR = 12'h000;
   localparam logic [11:0] SADC_STATUS_ADDR = 12'h004;
   localparam logic [3:0] SADC_CTRL_RESET = 4'h0;
   localparam int SADC_CTRL_WIDTH = 4;
   // status field positions
   localparam int SADC_STAT_CAL_BIT = 0;
   localparam int SADC_STAT_PD_BIT = 1;
   localparam int SADC_STAT_PHASE_BIT = 2;
   localparam int SADC_STAT_RUN_BIT = 3;

   typedef enum logic [1:0] {
      SADC_MODE_MASTER = 2'h0,
      SADC_MODE_SLAVE_HIGH = 2'h1,
      SADC_MODE_SLAVE_CTRL = 2'h2
   } sadc_mode_type;

   typedef struct packed {
      logic invert;
      logic ratio_high;
      sadc_mode_type mode;
   } sadc_ctrl_type;

   typedef struct packed {
      logic signed [17:0] left;
      logic signed [17:0] right;
   } sadc_pair_type;

   typedef enum logic [1:0] {
      SADC_PD = 2'b00,
      SADC_ALIGN = 2'b01,
      SADC_CAL = 2'b11,
      SADC_RUN = 2'b10
   } sadc_state_type;

   // divider limits (count wraps after limit)
   localparam logic [1:0] SADC_DIV2_LIMIT = 2'h1;
   localparam logic [1:0] SADC_DIV3_LIMIT = 2'h2;
   localparam logic [1:0] SADC_DIV3_START_EARLY = 2'h1;
   localparam logic [1:0] SADC_DIV3_START_LATE = 2'h2;
   localparam logic [1:0] SADC_ALIGN_LAST = 2'h1;
   // word slots per channel
   localparam logic [4:0] SADC_SLOT_LAST = 5'h1f;
   localparam logic [4:0] SADC_FRAME_FIRST = 5'h01;
   localparam logic [4:0] SADC_FRAME_LAST = 5'h10;
   localparam int SADC_FILL_BITS = 12;
   localparam int unsigned SADC_CAL_WORDS = 4096;
   // level thresholds, full scale = 0x8000
   localparam logic [17:0] SADC_LVL_O3 = 18'h0_b000;
   localparam logic [17:0] SADC_LVL_O2 = 18'h0_a000;
   localparam logic [17:0] SADC_LVL_O1 = 18'h0_9000;
   localparam logic [17:0] SADC_LVL_FS = 18'h0_8000;
   localparam logic [17:0] SADC_LVL_DB1 = 18'h0_7203;
   localparam logic [17:0] SADC_LVL_DB3 = 18'h0_59fe;
   localparam logic [17:0] SADC_LVL_DB6 = 18'h0_4027;
   localparam logic signed [17:0] SADC_POS_FS = 18'sh0_7fff;
   localparam logic signed [17:0] SADC_NEG_FS = 18'sh3_8000;
   localparam logic [15:0] SADC_SAT_POS = 16'h7fff;
   localparam logic [15:0] SADC_SAT_NEG = 16'h8000;
endpackage
`default_nettype wire

// ==== verification/sadc_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module sadc_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic chan_sel_o,
   input wire logic chan_sel_oe,
   input wire logic bit_clock_oe,
   input wire logic frame_window_o,
   input wire logic frame_window_oe,
   input wire logic filter_clock_out,
   input wire logic serial_out,
   input wire logic cal_busy
);
   logic [7:0] fw_q;
   // length of the current frame window pulse
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fw_q <= 8'h00;
      else
         fw_q <= frame_window_o ? fw_q + 8'h01 : 8'h00;
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_req;
      psel && penable && !pready;
   endsequence
   sequence s_edge;
      chan_sel_oe && $changed(chan_sel_o);
   endsequence
   property p_resp;
      s_req |=> pready;
   endproperty
   property p_once;
      pready |=> !pready;
   endproperty
   property p_err;
      pslverr |-> pready;
   endproperty
   property p_oe;
      chan_sel_oe == bit_clock_oe && bit_clock_oe == frame_window_oe;
   endproperty
   property p_fclk;
      filter_clock_out |=> !filter_clock_out;
   endproperty
   property p_gap;
      s_edge |-> !frame_window_o [*3];
   endproperty
   property p_len;
      chan_sel_oe && $fell(frame_window_o) |-> fw_q == 8'h40 || fw_q == 8'h60;
   endproperty
   property p_cal;
      cal_busy && frame_window_o && $past(frame_window_o) |-> !serial_out;
   endproperty
   a_resp: assert property (p_resp) else $error("no answer after access");
   a_once: assert property (p_once) else $error("ready longer than one cycle");
   a_err: assert property (p_err) else $error("error without ready");
   a_oe: assert property (p_oe) else $error("pin enables disagree");
   a_fclk: assert property (p_fclk) else $error("filter clock high too long");
   a_gap: assert property (p_gap) else $error("window too soon after channel edge");
   a_len: assert property (p_len) else $error("window length wrong");
   a_cal: assert property (p_cal) else $error("nonzero word in calibration");
endmodule
bind sadc_port sadc_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .chan_sel_o(chan_sel_o), .chan_sel_oe(chan_sel_oe),
   .bit_clock_oe(bit_clock_oe), .frame_window_o(frame_window_o), .frame_window_oe(frame_window_oe),
   .filter_clock_out(filter_clock_out), .serial_out(serial_out), .cal_busy(cal_busy));
`default_nettype wire

// ==== verification/sadc_far_end.sv ====
`timescale 1ns/1ns
`default_nettype none
module sadc_far_end #(
   parameter int HALF = 8
) (
   input wire logic pclk,
   input wire logic run,
   input wire logic gate_low,
   output logic chan_sel = 1'b0,
   output logic bit_clock = 1'b0,
   output logic frame_window
);
   int ph = 0;
   int bits = 0;
   assign frame_window = !gate_low;
   // clock stands still while not running; slower than recommended rate
   always @(posedge pclk)
   begin
      if (run && ph == HALF - 1)
      begin
         bit_clock <= !bit_clock;
         bits <= (bit_clock && bits == 31) ? 0 : bits + int'(bit_clock);
         if (bit_clock && bits == 31)
            chan_sel <= !chan_sel;
      end
      if (run)
         ph <= (ph == HALF - 1) ? 0 : ph + 1;
   end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
   import sadc_pkg::*;
   logic pclk, presetn, clk_en, psel, penable, pwrite, sample_valid, digital_powerdown, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, cs_i, bc_i, fw_i, cs_m, bc_m, fw_m, cs_o, cs_oe, bc_o, bc_oe, fw_o, fw_oe;
   logic fclk, sout, cal_busy, run, gate_low;
   logic modulator_clock_in;
   sadc_pair_type pair;
   int mismatches, samples_checked;
   logic [17:0] mags [8] = '{18'h0_b800, 18'h0_a800, 18'h0_9800, 18'h0_8800, 18'h0_7800, 18'h0_6000,
      18'h0_4800, 18'h0_1234};
   always_comb cs_i = cs_oe ? cs_o : cs_m;
   always_comb bc_i = bc_oe ? bc_o : bc_m;
   always_comb fw_i = fw_oe ? fw_o : fw_m;
   // board loop from the filter clock pin to the modulator clock pin
   always_comb modulator_clock_in = fclk;
   sadc_port #(.CAL_WORDS(4)) i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sample_pair(pair), .sample_valid(sample_valid), .digital_powerdown(digital_powerdown),
      .chan_sel_i(cs_i), .bit_clock_i(bc_i), .frame_window_i(fw_i), .chan_sel_o(cs_o), .chan_sel_oe(cs_oe),
      .bit_clock_o(bc_o), .bit_clock_oe(bc_oe), .frame_window_o(fw_o), .frame_window_oe(fw_oe),
      .filter_clock_out(fclk), .serial_out(sout), .cal_busy(cal_busy));
   sadc_far_end i_far (.pclk(pclk), .run(run), .gate_low(gate_low), .chan_sel(cs_m), .bit_clock(bc_m),
      .frame_window(fw_m));
   initial
   begin
      pclk = 0;
      forever #25 pclk = ~pclk;
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic tmo(input string m);
      mismatches++;
      $display("[FAIL] %0t timeout %s", $time, m);
      wrap_up;
   endtask
   task automatic waitv(ref logic s, input logic v, output int n);
      n = 0;
      while (s !== v && n < 6000)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= 6000)
         tmo("wait");
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      // one idle edge so the previous release and this setup never share a time step
      @(posedge pclk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         tmo("apb");
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic pulse(input sadc_pair_type v);
      pair <= v;
      sample_valid <= 1;
      @(posedge pclk);
      sample_valid <= 0;
   endtask
   task automatic grab(ref logic clk, input logic edg, output logic [31:0] w, output logic [31:0] f);
      logic p;
      int n, k;
      p = clk;
      k = 0;
      n = 0;
      while (k < 32 && n < 4000)
      begin
         @(posedge pclk);
         n++;
         if (clk === edg && p !== edg)
         begin
            w = {w[30:0], sout};
            f = {f[30:0], fw_o};
            k++;
         end
         p = clk;
      end
      if (k < 32)
         tmo("bits");
   endtask
   function automatic logic [30:0] expw(input int i, input logic r);
      logic [17:0] m;
      logic [15:0] d;
      m = mags[i];
      if (r)
         d = m > 18'h0_8000 ? 16'h8000 : 16'h0000 - m[15:0];
      else
         d = m > 18'h0_7fff ? 16'h7fff : m[15:0];
      return {d, 3'(7 - i), r, {11{!r}}};
   endfunction
   task automatic start(input logic [3:0] c);
      int n;
      presetn <= 0;
      digital_powerdown <= 1;
      repeat (8) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      apb(0, SADC_CTRL_ADDR, 32'h0000_0000);
      chk(rd, {28'h000_0000, SADC_CTRL_RESET}, "ctrl reset");
      apb(1, SADC_CTRL_ADDR, {28'h000_0000, c});
      apb(0, SADC_STATUS_ADDR, 32'h0000_0000);
      chk(rd[SADC_STAT_PD_BIT], 1, "powered down");
      digital_powerdown <= 0;
      waitv(cal_busy, 1, n);
      chk(n < 12, 1, "cal start");
      waitv(cal_busy, 0, n);
   endtask
   task automatic t_rate(input int per);
      int n, r, a, b;
      logic p;
      p = modulator_clock_in;
      r = 0;
      for (n = 0; n < 60; n++)
      begin
         @(posedge pclk);
         r += int'(modulator_clock_in && !p);
         p = modulator_clock_in;
      end
      chk(r, 60 / per, "filter clock");
      waitv(cs_o, 0, n);
      waitv(cs_o, 1, n);
      waitv(cs_o, 0, a);
      waitv(cs_o, 1, b);
      chk(a + b, 128 * per, "word rate");
      $display("done rate %0d", per);
   endtask
   task automatic t_master(input logic inv, input int cnt);
      logic [31:0] w, f;
      int n;
      for (int i = 0; i < cnt; i++)
      begin
         waitv(cs_o, 0, n);
         pulse({mags[i], 18'h0_0000 - mags[i]});
         waitv(cs_o, 1, n);
         // sample on the launching edge: rising, or falling when inverted
         grab(bc_o, !inv, w, f);
         pulse(36'h0_0000_0000);
         chk(w[31:1], expw(i, 0), "left");
         chk(f, 32'hffff_0000, "window");
         grab(bc_o, !inv, w, f);
         chk(w[31:1], expw(i, 1), "right");
      end
      $display("done master %0d", inv);
   endtask
   task automatic t_slave(input sadc_mode_type md);
      logic [31:0] w, f;
      int n;
      run <= 1;
      start({2'b00, md});
      waitv(cs_i, 0, n);
      gate_low <= (md == SADC_MODE_SLAVE_CTRL);
      pulse({mags[1], 18'h0_0000 - mags[1]});
      waitv(cs_i, 1, n);
      grab(bc_i, 1, w, f);
      if (md == SADC_MODE_SLAVE_CTRL)
         chk(w, 32'h0000_0000, "gated");
      else
         chk(w[31:1], expw(1, 0), "slave");
      gate_low <= 0;
      $display("done slave %0d", md);
   endtask
   task automatic t_regs;
      apb(1, SADC_CTRL_ADDR, 32'h0000_000e);
      apb(0, SADC_CTRL_ADDR, 32'h0000_0000);
      chk(rd, 32'h0000_000e, "ctrl rw");
      apb(1, SADC_STATUS_ADDR, 32'hffff_ffff);
      chk(err, 0, "status write");
      apb(0, 12'h0f0, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "unmapped read data");
      chk(err, 1, "unmapped read error");
      $display("done regs");
   endtask
   initial
   begin
      presetn = 0;
      clk_en = 1;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      pair = 0;
      sample_valid = 0;
      digital_powerdown = 1;
      run = 0;
      gate_low = 0;
      mismatches = 0;
      samples_checked = 0;
      start(4'h0);
      t_rate(2);
      t_master(0, 8);
      start(4'h4);
      t_rate(3);
      apb(0, SADC_STATUS_ADDR, 32'h0000_0000);
      chk(rd[3:2], 2'b10, "phase late, running");
      t_master(0, 2);
      start(4'h8);
      t_master(1, 2);
      t_slave(SADC_MODE_SLAVE_HIGH);
      t_slave(SADC_MODE_SLAVE_CTRL);
      t_regs;
      wrap_up;
   end
endmodule
`default_nettype wire
